//--- rtl/alb_pkg.sv
package alb_pkg;
  localparam logic [11:0] ALB_LOOPBACK_OFFSET = 12'h100;
  localparam logic [31:0] ALB_LOOPBACK_RESET = 32'h0000_0000;
  localparam int ALB_ENABLE_BIT = 0;
  localparam int ALB_TS_BIT = 3;
  localparam int ALB_DIFFERENTIAL_FLAG_BIT = 4;
  localparam int ALB_CONTINUATION_FLAG_BIT = 5;
  localparam int ALB_CNT_LSB = 6;
  localparam int ALB_CNT_MSB = 9;
  localparam logic [3:0] ALB_CNT_RESET = 4'h0;
  localparam logic [31:0] ALB_UNMAPPED_DATA = 32'h0000_0000;
endpackage

//--- rtl/alb_sample_if.sv
`timescale 1ns/1ps
interface alb_sample_if;
  logic sample_taken;
  logic enable;
  logic [3:0] count;
  modport counter (input sample_taken, input enable, output count);
  modport user (output sample_taken, output enable, input count);
endinterface

//--- rtl/alb_sample_counter.sv
`timescale 1ns/1ps
module alb_sample_counter (
  input wire logic pclk,
  input wire logic presetn,
  alb_sample_if.counter sif
);
  logic [3:0] count;
  logic [3:0] next_count;

  // Restart at zero each time loopback is off so every session starts fresh
  assign next_count = !sif.enable ? alb_pkg::ALB_CNT_RESET :
                      sif.sample_taken ? count + 4'h1 : count;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= alb_pkg::ALB_CNT_RESET;
    end else begin
      count <= next_count;
    end
  end

  assign sif.count = count;
endmodule // alb_sample_counter

//--- rtl/alb_loopback.sv
// The APB register port was left to the implementer.
`timescale 1ns/1ps
module alb_loopback (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic fifo_rd,
  input wire logic [31:0] fifo_data,
  input wire logic sample_continuation_flag,
  input wire logic sample_differential_flag,
  input wire logic sample_ts,
  output logic [31:0] result_data,
  output logic loopback_active
);
  logic loopback_enable;
  logic [31:0] ro_word;
  logic [31:0] reg_word;
  logic sel_loopback;
  logic wr_loopback;
  logic rd_access;
  logic [31:0] next_prdata;
  logic [31:0] next_result;

  alb_sample_if sif ();

  assign sif.enable = loopback_enable;
  assign sif.sample_taken = fifo_rd & loopback_enable;

  alb_sample_counter u_counter (
    .pclk(pclk),
    .presetn(presetn),
    .sif(sif)
  );

  assign sel_loopback = (paddr == alb_pkg::ALB_LOOPBACK_OFFSET);
  assign wr_loopback = psel & penable & pwrite & sel_loopback;
  assign rd_access = psel & ~penable & ~pwrite;

  // Read-only portion, as seen by a FIFO read in loopback
  always_comb begin
    ro_word = 32'h0000_0000;
    ro_word[alb_pkg::ALB_CNT_MSB:alb_pkg::ALB_CNT_LSB] = sif.count;
    ro_word[alb_pkg::ALB_CONTINUATION_FLAG_BIT] = sample_continuation_flag;
    ro_word[alb_pkg::ALB_DIFFERENTIAL_FLAG_BIT] = sample_differential_flag;
    ro_word[alb_pkg::ALB_TS_BIT] = sample_ts;
  end

  always_comb begin
    reg_word = 32'h0000_0000;
    reg_word[alb_pkg::ALB_ENABLE_BIT] = loopback_enable;
  end

  // Unmapped reads give zero without error; setup-phase capture gives zero wait
  assign next_prdata = !rd_access ? prdata :
                       sel_loopback ? reg_word : alb_pkg::ALB_UNMAPPED_DATA;
  assign next_result = loopback_enable ? ro_word : fifo_data;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loopback_enable <= alb_pkg::ALB_LOOPBACK_RESET[0];
    end else if (wr_loopback) begin
      loopback_enable <= pwdata[alb_pkg::ALB_ENABLE_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      result_data <= 32'h0000_0000;
      loopback_active <= 1'b0;
      pready <= 1'b1;
      pslverr <= 1'b0;
    end else begin
      prdata <= next_prdata;
      result_data <= next_result;
      loopback_active <= loopback_enable;
      pready <= 1'b1;
      pslverr <= 1'b0;
    end
  end

  property p_write_enables;
    @(posedge pclk) disable iff (!presetn)
    wr_loopback |=> (loopback_enable == $past(pwdata[0]));
  endproperty
  a_write_enables: assert property (p_write_enables) else $error("enable bit not written");

  property p_loop_result;
    @(posedge pclk) disable iff (!presetn)
    loopback_enable |=> (result_data[31:10] == 22'h0 && result_data[9:6] == $past(sif.count)
                         && result_data[5] == $past(sample_continuation_flag) && result_data[2:0] == 3'h0);
  endproperty
  a_loop_result: assert property (p_loop_result) else $error("loopback word wrong");

  property p_normal_result;
    @(posedge pclk) disable iff (!presetn)
    !loopback_enable |=> (result_data == $past(fifo_data));
  endproperty
  a_normal_result: assert property (p_normal_result) else $error("normal data not passed");

  sequence s_loop_read;
    loopback_enable && fifo_rd;
  endsequence
  property p_count_step;
    @(posedge pclk) disable iff (!presetn)
    s_loop_read ##1 loopback_enable |-> (sif.count == $past(sif.count) + 4'h1);
  endproperty
  a_count_step: assert property (p_count_step) else $error("counter did not step");

  // Counter clears one edge after the enable drops
  property p_count_clear;
    @(posedge pclk) disable iff (!presetn)
    !loopback_enable |=> (sif.count == 4'h0);
  endproperty
  a_count_clear: assert property (p_count_clear) else $error("counter not zero when off");

  property p_reset_off;
    @(posedge pclk) $rose(presetn) |-> !loopback_enable;
  endproperty
  a_reset_off: assert property (p_reset_off) else $error("loopback on after reset");

  property p_active_flag;
    @(posedge pclk) disable iff (!presetn)
    1'b1 |=> (loopback_active == $past(loopback_enable));
  endproperty
  a_active_flag: assert property (p_active_flag) else $error("active flag lags wrong");

  property p_read_back;
    @(posedge pclk) disable iff (!presetn)
    rd_access && sel_loopback |=> (prdata == {31'h0, $past(loopback_enable)});
  endproperty
  a_read_back: assert property (p_read_back) else $error("register readback wrong");

  // Flags of the sample being read land beside the counter
  property p_differential_flag_flag;
    @(posedge pclk) disable iff (!presetn)
    loopback_enable |=> (result_data[alb_pkg::ALB_DIFFERENTIAL_FLAG_BIT] == $past(sample_differential_flag));
  endproperty
  a_differential_flag_flag: assert property (p_differential_flag_flag) else $error("differential flag wrong");

  property p_ts_flag;
    @(posedge pclk) disable iff (!presetn)
    loopback_enable |=> (result_data[alb_pkg::ALB_TS_BIT] == $past(sample_ts));
  endproperty
  a_ts_flag: assert property (p_ts_flag) else $error("temperature flag wrong");

  property p_count_hold;
    @(posedge pclk) disable iff (!presetn)
    loopback_enable && !fifo_rd |=> (sif.count == $past(sif.count));
  endproperty
  a_count_hold: assert property (p_count_hold) else $error("counter moved without a read");

  // Four bits only: the seventeenth sample repeats the first count
  sequence s_loop_read_top;
    loopback_enable && fifo_rd && (sif.count == 4'hf);
  endsequence
  property p_count_wrap;
    @(posedge pclk) disable iff (!presetn)
    s_loop_read_top |=> (sif.count == 4'h0);
  endproperty
  a_count_wrap: assert property (p_count_wrap) else $error("counter did not wrap");

  sequence s_enable_write;
    wr_loopback && pwdata[alb_pkg::ALB_ENABLE_BIT];
  endsequence
  sequence s_enter_loop;
    loopback_enable ##1 loopback_active;
  endsequence
  property p_enter_loop;
    @(posedge pclk) disable iff (!presetn)
    s_enable_write |=> s_enter_loop;
  endproperty
  a_enter_loop: assert property (p_enter_loop) else $error("loopback not entered");

  sequence s_disable_write;
    wr_loopback && !pwdata[alb_pkg::ALB_ENABLE_BIT];
  endsequence
  sequence s_leave_loop;
    !loopback_enable ##1 !loopback_active;
  endsequence
  property p_leave_loop;
    @(posedge pclk) disable iff (!presetn)
    s_disable_write |=> s_leave_loop;
  endproperty
  a_leave_loop: assert property (p_leave_loop) else $error("loopback not left");

  // Only an access-phase hit on the register may change the mode
  property p_enable_stable;
    @(posedge pclk) disable iff (!presetn)
    !wr_loopback |=> $stable(loopback_enable);
  endproperty
  a_enable_stable: assert property (p_enable_stable) else $error("enable changed without a write");

  property p_unmapped_read;
    @(posedge pclk) disable iff (!presetn)
    rd_access && !sel_loopback |=> (prdata == alb_pkg::ALB_UNMAPPED_DATA);
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");

  // Read data stands through the access phase and after it
  property p_prdata_hold;
    @(posedge pclk) disable iff (!presetn)
    !rd_access |=> $stable(prdata);
  endproperty
  a_prdata_hold: assert property (p_prdata_hold) else $error("read data moved");

  property p_zero_wait;
    @(posedge pclk) disable iff (!presetn)
    psel && penable |-> (pready && !pslverr);
  endproperty
  a_zero_wait: assert property (p_zero_wait) else $error("access not completed at once");

  property p_reset_outputs;
    @(posedge pclk) $rose(presetn) |-> (result_data == 32'h0000_0000 && prdata == 32'h0000_0000
                                        && !loopback_active && pready && !pslverr);
  endproperty
  a_reset_outputs: assert property (p_reset_outputs) else $error("outputs not at reset values");
endmodule // alb_loopback

//--- dv/adc_loopback_test_tb_top.sv
`timescale 1ns/1ps
module adc_loopback_test_tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic fifo_rd = 1'b0;
  logic [31:0] fifo_data = 32'h0;
  logic sample_continuation_flag = 1'b0;
  logic sample_differential_flag = 1'b0;
  logic sample_ts = 1'b0;
  logic [31:0] prdata, result_data, rd;
  logic pready, pslverr, loopback_active;
  int bad_count = 0;
  int total_checks = 0;
  always #25 pclk = ~pclk;
  alb_loopback DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fifo_rd(fifo_rd), .fifo_data(fifo_data), .sample_continuation_flag(sample_continuation_flag), .sample_differential_flag(sample_differential_flag),
    .sample_ts(sample_ts), .result_data(result_data), .loopback_active(loopback_active));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Waits on pready with a bound; the slave decides the wait states
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
    if (n == 20) bad_count++;
    rd = prdata;
    chk({31'h0, pslverr}, 32'h0);
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic samp(input logic [2:0] f, input logic [31:0] d);
    @(posedge pclk);
    fifo_rd <= 1'b1; fifo_data <= d;
    {sample_continuation_flag, sample_differential_flag, sample_ts} <= f;
    @(posedge pclk);
    fifo_rd <= 1'b0;
    #1;
  endtask
  task automatic t_reset;
    apb(1'b0, 12'h100, 32'h0); chk(rd, 32'h0);
    chk({31'h0, loopback_active}, 32'h0);
    samp(3'h7, 32'h1234_5678); chk(result_data, 32'h1234_5678);
    apb(1'b0, 12'h104, 32'h0); chk(rd, 32'h0);
    $display("reset test done");
  endtask
  task automatic t_enable;
    apb(1'b1, 12'h100, 32'hffff_ffff);
    apb(1'b0, 12'h100, 32'h0); chk(rd, 32'h1);
    chk({31'h0, loopback_active}, 32'h1);
    $display("enable test done");
  endtask
  // Runs past 15 so the counter wrap is seen
  task automatic t_loop;
    for (int i = 0; i < 18; i++) begin
      samp(3'(i), 32'hdead_beef);
      chk(result_data, {22'h0, 4'(i), 3'(i), 3'h0});
    end
    $display("loop test done");
  endtask
  task automatic t_disable;
    apb(1'b1, 12'h100, 32'h0);
    apb(1'b0, 12'h100, 32'h0); chk(rd, 32'h0);
    samp(3'h5, 32'hcafe_0001); chk(result_data, 32'hcafe_0001);
    $display("disable test done");
  endtask
  // Second reset mid-run, with loopback on and the counter advanced
  task automatic t_midreset;
    apb(1'b1, 12'h100, 32'h0000_0001);
    apb(1'b0, 12'h100, 32'h0); chk(rd, 32'h1);
    samp(3'h2, 32'h0); chk(result_data, 32'h0000_0010);
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    #1;
    chk(prdata, 32'h0);
    chk(result_data, 32'h0);
    chk({31'h0, loopback_active}, 32'h0);
    chk({31'h0, pready}, 32'h1);
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h100, 32'h0); chk(rd, 32'h0);
    samp(3'h7, 32'h0000_00a5); chk(result_data, 32'h0000_00a5);
    $display("mid-run reset test done");
  endtask
  task automatic complete_run;
    $display("checks=%0d mismatches=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_enable;
    t_loop;
    t_disable;
    t_midreset;
    complete_run;
  end
  // About 90 cycles expected; far more allowed
  initial begin
    #200000;
    bad_count++;
    complete_run;
  end
endmodule // adc_loopback_test_tb_top
